// [src/crb_consts.svh]
`ifndef CRB_CONSTS_SVH
`define CRB_CONSTS_SVH

`define CRB_DATA_W 25
`define CRB_HALF_W 14
`define CRB_SYNC_STAGES 3
`define CRB_GATE_1TO1 25'h1FFFFB6
`define CRB_GATE_REG_A 25'h0003FB6
`define CRB_GATE_REG_B 25'h0001BBF
`define CRB_LANES_1TO1 25'h1FFFFFF
`define CRB_LANES_1TO2 25'h0003FFF
`define CRB_RESET_DATA 25'h0000000
`define CRB_CS_BIT 6
`define CRB_CKE_BIT_LOW 0
`define CRB_ODT_BIT_LOW 3
`define CRB_CKE_BIT_REG_B 13
`define CRB_ODT_BIT_REG_B 10
`define CRB_CLK_PERIOD_NS 10
`define CRB_ACT_TIME_NS 10
`define CRB_ACT_CYCLES ((`CRB_ACT_TIME_NS + `CRB_CLK_PERIOD_NS - 1) / `CRB_CLK_PERIOD_NS)
`define CRB_INACT_TIME_NS 15
`define CRB_INACT_CYCLES ((`CRB_INACT_TIME_NS + `CRB_CLK_PERIOD_NS - 1) / `CRB_CLK_PERIOD_NS)

`endif

// [src/crb_pkg.sv]
`include "crb_consts.svh"

package crb_pkg;

  typedef enum logic [1:0] {MODE_1TO1, MODE_REG_A, MODE_REG_B} mode_e;

  typedef struct packed {
    logic [`CRB_DATA_W-1:0] data;
    logic cs_dev;
    logic cs_sec;
    logic ck_true;
    logic ck_comp;
    logic cfg_ab;
    logic cfg_width;
  } pin_s;

endpackage : crb_pkg

// [src/configurable_registered_buffer.sv]
// How it works
// - Two configuration pins pick one of three modes
// - Reset clears registers, forces all outputs low except in_ready_o, which is high
// - Capture at clock crossing; hold while clocks static
// - Both chip selects high freeze gated outputs
// - Clock enable and termination channels never frozen
// - Chip select channel always follows its input
// - Unused inputs ignored, unused outputs driven low
// - Gating applies only to mode's listed channels
// - Config pins: low A/one-to-one, high B/one-to-two
// - Reset beats chip select gating
`timescale 1ns/1ps
`default_nettype none
`include "crb_consts.svh"

module configurable_registered_buffer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clk_true_i,
  input wire logic clk_comp_i,
  input wire logic pinout_a_b_select_i,
  input wire logic fanout_width_select_i,
  input wire logic device_chip_select_in_i,
  input wire logic second_chip_select_in_i,
  input wire logic [`CRB_DATA_W-1:0] buffered_input_bit_i,
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic in_ready_o,
  output logic dropped_o,
  output logic [`CRB_DATA_W-1:0] buffered_output_bit_a_o,
  output logic [`CRB_HALF_W-1:0] buffered_output_bit_b_o
);
  import crb_pkg::*;

  localparam int PIN_W = $bits(pin_s);

  function automatic logic [`CRB_DATA_W-1:0] gate_mask(input mode_e m);
    case (m)
      MODE_1TO1: gate_mask = `CRB_GATE_1TO1;
      MODE_REG_A: gate_mask = `CRB_GATE_REG_A;
      MODE_REG_B: gate_mask = `CRB_GATE_REG_B;
      default: gate_mask = `CRB_GATE_1TO1;
    endcase
  endfunction : gate_mask

  function automatic logic [`CRB_DATA_W-1:0] lane_mask(input mode_e m);
    case (m)
      MODE_1TO1: lane_mask = `CRB_LANES_1TO1;
      default: lane_mask = `CRB_LANES_1TO2;
    endcase
  endfunction : lane_mask

  // Pin synchroniser; a bit counts only once stages two and three agree
  logic [PIN_W-1:0] sync_r [`CRB_SYNC_STAGES];
  logic [PIN_W-1:0] filt_r;
  logic [PIN_W-1:0] agree;
  logic [PIN_W-1:0] filt_nxt;
  pin_s pins_raw;
  pin_s pins;

  assign pins_raw.data = buffered_input_bit_i;
  assign pins_raw.cs_dev = device_chip_select_in_i;
  assign pins_raw.cs_sec = second_chip_select_in_i;
  assign pins_raw.ck_true = clk_true_i;
  assign pins_raw.ck_comp = clk_comp_i;
  assign pins_raw.cfg_ab = pinout_a_b_select_i;
  assign pins_raw.cfg_width = fanout_width_select_i;

  genvar g;
  generate
    for (g = 0; g < `CRB_SYNC_STAGES; g++)
    begin : g_sync
      if (g == 0)
      begin : g_first
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
          if (!rst_n_i)
            sync_r[g] <= '0;
          else
            sync_r[g] <= pins_raw;
        end
      end
      else
      begin : g_next
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
          if (!rst_n_i)
            sync_r[g] <= '0;
          else
            sync_r[g] <= sync_r[g-1];
        end
      end
    end
  endgenerate

  assign agree = ~(sync_r[1] ^ sync_r[2]);
  assign filt_nxt = (sync_r[2] & agree) | (filt_r & ~agree);
  assign pins = pin_s'(filt_r);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      filt_r <= '0;
    else
      filt_r <= filt_nxt;
  end

  // Mode decode; pins are meant to be strapped, so no glitch guard beyond the pin filter
  mode_e mode;
  assign mode = !pins.cfg_width ? MODE_1TO1 :
                (pins.cfg_ab ? MODE_REG_B : MODE_REG_A);
  wire wide = (mode != MODE_1TO1);

  // Crossing: true clock high and complement low, seen fresh
  logic ck_st_r;
  wire ck_st = pins.ck_true & ~pins.ck_comp;
  wire crossing = ck_st & ~ck_st_r;
  wire both_cs_high = pins.cs_dev & pins.cs_sec;
  wire [`CRB_DATA_W-1:0] gmask = gate_mask(mode);
  wire [`CRB_DATA_W-1:0] lanes = lane_mask(mode);
  wire [`CRB_DATA_W-1:0] hold_mask = both_cs_high ? gmask : '0;
  wire [`CRB_DATA_W-1:0] fresh = pins.data & lanes;

  logic [`CRB_DATA_W-1:0] cap_r;
  logic [`CRB_DATA_W-1:0] cap_nxt;
  logic cap_v_r;
  logic push;
  wire cap_free = !cap_v_r || push;
  wire take = crossing && cap_free;

  assign cap_nxt = (cap_r & hold_mask & lanes) | (fresh & ~hold_mask);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ck_st_r <= 1'b0;
      cap_r <= `CRB_RESET_DATA;
      cap_v_r <= 1'b0;
      dropped_o <= 1'b0;
    end
    else
    begin
      ck_st_r <= ck_st;
      dropped_o <= crossing && !cap_free;
      if (take)
        cap_r <= cap_nxt;
      if (take)
        cap_v_r <= 1'b1;
      else if (push)
        cap_v_r <= 1'b0;
    end
  end

  // Two-entry skid buffer: a stalled receiver loses no pushed word; a crossing with capture full is dropped
  logic [`CRB_DATA_W-1:0] out_r;
  logic [`CRB_DATA_W-1:0] skid_r;
  logic out_v_r;
  logic skid_v_r;
  wire pop = out_v_r && out_ready_i;
  assign in_ready_o = !skid_v_r;
  assign push = cap_v_r && in_ready_o;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_r <= `CRB_RESET_DATA;
      skid_r <= `CRB_RESET_DATA;
      out_v_r <= 1'b0;
      skid_v_r <= 1'b0;
    end
    else if (!out_v_r || pop)
    begin
      if (skid_v_r)
      begin
        out_r <= skid_r;
        out_v_r <= 1'b1;
        skid_v_r <= 1'b0;
      end
      else
      begin
        out_v_r <= push;
        if (push)
          out_r <= cap_r;
      end
    end
    else if (push)
    begin
      skid_r <= cap_r;
      skid_v_r <= 1'b1;
    end
  end

  assign out_valid_o = out_v_r;
  assign buffered_output_bit_a_o = out_r & lanes;
  assign buffered_output_bit_b_o = wide ? out_r[`CRB_HALF_W-1:0] : '0;

  AST_RESET_LOW: assert property (@(posedge clk_i)
    !rst_n_i |-> (buffered_output_bit_a_o == '0 && buffered_output_bit_b_o == '0 && !out_valid_o))
    else $error("outputs not low under reset");

  AST_CS_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (take && both_cs_high) |=> ((cap_r & $past(gmask)) == ($past(cap_r) & $past(gmask))))
    else $error("gated channels changed while both selects high");

  AST_CS_FOLLOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (take && !both_cs_high) |=> (cap_r == $past(fresh)))
    else $error("capture did not follow inputs with a select low");

  AST_UNGATED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take |=> ((cap_r & ~$past(gmask)) == ($past(fresh) & ~$past(gmask))))
    else $error("ungated channel was frozen");

  AST_STATIC_CLK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !take |=> $stable(cap_r))
    else $error("capture changed without a clock crossing");

  AST_UNUSED_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wide |-> (buffered_output_bit_a_o[`CRB_DATA_W-1:`CRB_HALF_W] == '0))
    else $error("unused output not low");

  AST_COPY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wide |-> (buffered_output_bit_b_o == buffered_output_bit_a_o[`CRB_HALF_W-1:0]))
    else $error("A and B copies differ");

  AST_STALL_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_r)))
    else $error("output word lost under stall");

  AST_MODE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pins.cfg_width && pins.cfg_ab) |-> (gmask == `CRB_GATE_REG_B))
    else $error("register-B gating not selected");

  AST_MODE_A: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pins.cfg_width && !pins.cfg_ab)
      |-> (gmask == `CRB_GATE_REG_A && lanes == `CRB_LANES_1TO2))
    else $error("register-A gating not selected");

  AST_MODE_1TO1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !pins.cfg_width |-> (gmask == `CRB_GATE_1TO1 && lanes == `CRB_LANES_1TO1))
    else $error("one-to-one gating not selected");

  AST_NARROW_B: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wide |-> (buffered_output_bit_b_o == '0))
    else $error("B copies driven in one-to-one mode");

  AST_RESET_RELEASE: assert property (@(posedge clk_i)
    $rose(rst_n_i) |-> (cap_r == `CRB_RESET_DATA && !out_valid_o && !dropped_o))
    else $error("state not clear at reset release");

  // Selects held high while in reset must not keep any old word
  AST_RESET_PRIORITY: assert property (@(posedge clk_i)
    (!rst_n_i && device_chip_select_in_i && second_chip_select_in_i)
      |-> (cap_r == `CRB_RESET_DATA && buffered_output_bit_a_o == '0))
    else $error("select gating overrode reset");

  AST_TAKE_VALID: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take |=> cap_v_r)
    else $error("captured word not marked valid");

  // Fixed pin positions, not the mask table, so a wrong mask shows up
  AST_CS_CHANNEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take |=> (cap_r[`CRB_CS_BIT] == $past(fresh[`CRB_CS_BIT])))
    else $error("chip select channel did not follow its input");

  AST_CKE_ODT_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (take && both_cs_high && mode != MODE_REG_B)
      |=> (cap_r[`CRB_CKE_BIT_LOW] == $past(fresh[`CRB_CKE_BIT_LOW])
        && cap_r[`CRB_ODT_BIT_LOW] == $past(fresh[`CRB_ODT_BIT_LOW])))
    else $error("enable or termination channel frozen");

  AST_CKE_ODT_B: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (take && both_cs_high && mode == MODE_REG_B)
      |=> (cap_r[`CRB_CKE_BIT_REG_B] == $past(fresh[`CRB_CKE_BIT_REG_B])
        && cap_r[`CRB_ODT_BIT_REG_B] == $past(fresh[`CRB_ODT_BIT_REG_B])))
    else $error("enable or termination channel frozen in register-B");

  // Buffer checks: words leave in order and none vanish silently
  AST_DROP_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (crossing && !cap_free) |=> dropped_o)
    else $error("lost crossing not flagged");

  AST_NO_DROP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(crossing && !cap_free) |=> !dropped_o)
    else $error("drop flagged without a lost crossing");

  AST_CAP_HELD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cap_v_r && !push) |=> cap_v_r)
    else $error("captured word vanished before moving on");

  AST_FIRST_WORD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (push && !out_valid_o) |=> (out_valid_o && out_r == $past(cap_r)))
    else $error("captured word did not reach the output stage");

  AST_SKID_TO_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pop && skid_v_r) |=> (out_valid_o && out_r == $past(skid_r)))
    else $error("skid word not moved to the output stage");

  AST_POP_EMPTIES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pop && !skid_v_r && !push) |=> !out_valid_o)
    else $error("output still valid after last word left");

endmodule : configurable_registered_buffer

`default_nettype wire

// [verification/crb_load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module crb_load_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic out_ready_o
);
  logic phase_r;
  // Slow load accepts every other cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i) phase_r <= 1'b0;
    else phase_r <= ~phase_r;
  end
  assign out_ready_o = ~stall_i & (~slow_i | phase_r);
endmodule : crb_load_model
`default_nettype wire

// [verification/configurable_registered_buffer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "crb_consts.svh"
module configurable_registered_buffer_tb_top;
  import crb_pkg::*;
  logic clk_i = 1'b0, rst_n = 1'b0, ck_t = 1'b0, ck_c = 1'b1, cfg_ab = 1'b0, cfg_w = 1'b0;
  logic cs_d = 1'b1, cs_s = 1'b1, stall = 1'b1, slow = 1'b0, ready, vld, in_rdy, drop;
  logic [`CRB_DATA_W-1:0] din = '0, qa, a, gate, lanes, e;
  logic [`CRB_HALF_W-1:0] qb, b;
  int n_fail = 0, samples_checked = 0, cycles = 0, n_drop = 0;
  configurable_registered_buffer uut (.clk_i(clk_i), .rst_n_i(rst_n), .clk_true_i(ck_t),
    .clk_comp_i(ck_c), .pinout_a_b_select_i(cfg_ab), .fanout_width_select_i(cfg_w),
    .device_chip_select_in_i(cs_d), .second_chip_select_in_i(cs_s),
    .buffered_input_bit_i(din), .out_ready_i(ready), .out_valid_o(vld), .in_ready_o(in_rdy),
    .dropped_o(drop), .buffered_output_bit_a_o(qa), .buffered_output_bit_b_o(qb));
  crb_load_model load (.clk_i(clk_i), .rst_n_i(rst_n), .stall_i(stall), .slow_i(slow),
    .out_ready_o(ready));
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  task print_verdict();
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i)
  begin
    cycles++;
    if (drop === 1'b1) n_drop++;
    if (cycles == 5000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  task check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One full crossing: high phase, then back low
  task send(input logic [`CRB_DATA_W-1:0] w, input logic frz);
    @(posedge clk_i);
    din <= w;
    cs_d <= frz;
    cs_s <= frz;
    ck_t <= 1'b1;
    ck_c <= 1'b0;
    repeat (6) @(posedge clk_i);
    ck_t <= 1'b0;
    ck_c <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : send
  task get(output logic [`CRB_DATA_W-1:0] wa, output logic [`CRB_HALF_W-1:0] wb);
    int k;
    k = 0;
    @(posedge clk_i);
    while (!(vld === 1'b1 && ready === 1'b1) && k < 200)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 200) n_fail++;
    wa = qa;
    wb = qb;
  endtask : get
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      cfg_ab <= (m == 2);
      cfg_w <= (m != 0);
      cs_d <= 1'b1;
      cs_s <= 1'b1;
      din <= '0;
      stall <= 1'b1;
      slow <= (m == 1);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk_i);
      check({vld, qa, qb}, 0);
      check(in_rdy, 1'b1);
      if (m == 3) break;
      rst_n <= 1'b1;
      repeat (10) @(posedge clk_i);
      gate = m == 0 ? `CRB_GATE_1TO1 : m == 1 ? `CRB_GATE_REG_A : `CRB_GATE_REG_B;
      lanes = m == 0 ? `CRB_LANES_1TO1 : `CRB_LANES_1TO2;
      send(25'h1555555, 1'b0);
      send(25'h0AAAAAA, 1'b1);
      stall <= 1'b0;
      get(a, b);
      check(a, 25'h1555555 & lanes);
      check(b, m != 0 ? 14'h1555 : 14'h0000);
      e = ((25'h0AAAAAA & ~gate) | (25'h1555555 & gate)) & lanes;
      get(a, b);
      check(a, e);
      check(b, m != 0 ? e[`CRB_HALF_W-1:0] : 14'h0000);
      repeat (20) @(posedge clk_i);
      check(vld, 1'b0);
      stall <= 1'b1;
      for (int k = 0; k < 4; k++) send(25'h1555555 >> k, 1'b0);
      check(in_rdy, 1'b0);
      check(n_drop, m + 1);
      stall <= 1'b0;
      for (int k = 0; k < 3; k++)
      begin
        get(a, b);
        check(a, (25'h1555555 >> k) & lanes);
      end
      stall <= 1'b1;
      send(25'h1555555, 1'b1);
      check(vld, 1'b1);
    end
    print_verdict();
  end
endmodule : configurable_registered_buffer_tb_top
`default_nettype wire
